/* File: design/fspc_regs.svh */
// Purpose: Register offsets, field positions and timing counts for the
//          flash self-programming controller.
// Assumes: Included by bare name; definitions only.
// Notes:   Offsets are I/O-space addresses of the control register.
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define FSPC_CTRL_OFFSET     6'h37
`define FSPC_CTRL_RESET      8'h00

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define FSPC_BIT_STORE_EN    0
`define FSPC_BIT_PAGE_ERASE  1
`define FSPC_BIT_PAGE_WRITE  2
`define FSPC_BIT_READ_FUSE   3
`define FSPC_BIT_CLEAR_BUF   4

// Accepted low five-bit command patterns
`define FSPC_CMD_CLEAR       5'h11
`define FSPC_CMD_READ_FUSE   5'h09
`define FSPC_CMD_WRITE       5'h05
`define FSPC_CMD_ERASE       5'h03
`define FSPC_CMD_LOAD        5'h01

// ----------------------------------------------------------------------
// Timing counts, in clock cycles
// ----------------------------------------------------------------------
`define FSPC_STORE_WINDOW    3'h4
`define FSPC_LOAD_WINDOW     3'h3

`endif

/* File: design/fspc_pkg.sv */
// Purpose: Types shared by both ends of the flash self-programming link.
// Assumes: Nothing.
// Notes:   Constants live in fspc_regs.svh.
`default_nettype none

package fspc_pkg;

	// Armed command after a control-register write
	typedef enum logic [2:0] {
		FSPC_ARM_NONE,
		FSPC_ARM_LOAD,
		FSPC_ARM_ERASE,
		FSPC_ARM_WRITE,
		FSPC_ARM_FUSE
	} fspc_arm_e;

	// Host sequencing states
	typedef enum logic [2:0] {
		FSPC_H_IDLE,
		FSPC_H_CTRL,
		FSPC_H_ISSUE,
		FSPC_H_WAIT,
		FSPC_H_DONE
	} fspc_host_e;

endpackage : fspc_pkg

`default_nettype wire

/* File: design/fspc_if.sv */
// Purpose: Link between the processor core and the self-programming block.
// Assumes: Single clock; all signals synchronous to it.
// Notes:   Strobes are one-cycle pulses; data and address stand with them.
`timescale 1ns/1ps
`default_nettype none

interface fspc_if #(
	parameter int ADDR_W = 16
);
	// Register access
	logic              io_wr;
	logic              io_rd;
	logic [5:0]        io_addr;
	logic [7:0]        io_wdata;
	logic [7:0]        io_rdata;
	// Program memory instructions
	logic              store_prog_mem_instr;
	logic              load_prog_mem_instr;
	logic [ADDR_W-1:0] z_pointer;
	logic [15:0]       write_data_pair;
	logic              fuse_valid;
	logic [7:0]        fuse_data;
	logic              core_stall;

	modport dev (
		input  io_wr, io_rd, io_addr, io_wdata,
		input  store_prog_mem_instr, load_prog_mem_instr,
		input  z_pointer, write_data_pair,
		output io_rdata, fuse_valid, fuse_data, core_stall
	);

	modport host (
		output io_wr, io_rd, io_addr, io_wdata,
		output store_prog_mem_instr, load_prog_mem_instr,
		output z_pointer, write_data_pair,
		input  io_rdata, fuse_valid, fuse_data, core_stall
	);
endinterface : fspc_if

`default_nettype wire

/* File: design/fspc_device.sv */
// Purpose: Flash self-programming controller, device end.
// Assumes: Core presents store/load strobes for one cycle with pointer and
//          data; the flash macro answers each request with a done pulse.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_regs.svh"

module fspc_device #(
	parameter int WORD_BITS = 5,
	parameter int PAGE_BITS = 6,
	parameter int ADDR_W    = 16
) (
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 resetn_in,
	// Core link
	fspc_if.dev                       core,
	// EEPROM status
	input  wire logic                 eeprom_write_active_bit_in,
	// Fuse and lock sources
	input  wire logic [7:0]           fuse_bits_in,
	input  wire logic [7:0]           lock_bits_in,
	// Flash macro
	output logic                      flash_erase_req_out,
	output logic                      flash_write_req_out,
	output logic [PAGE_BITS-1:0]      flash_page_out,
	output logic [16*(1<<WORD_BITS)-1:0] flash_page_data_out,
	input  wire logic                 flash_done_in
);
	localparam int WORDS = 1 << WORD_BITS;

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	function automatic fspc_pkg::fspc_arm_e decode_cmd(input logic [4:0] c);
		case (c)
			`FSPC_CMD_LOAD:      decode_cmd = fspc_pkg::FSPC_ARM_LOAD;
			`FSPC_CMD_ERASE:     decode_cmd = fspc_pkg::FSPC_ARM_ERASE;
			`FSPC_CMD_WRITE:     decode_cmd = fspc_pkg::FSPC_ARM_WRITE;
			`FSPC_CMD_READ_FUSE: decode_cmd = fspc_pkg::FSPC_ARM_FUSE;
			default:             decode_cmd = fspc_pkg::FSPC_ARM_NONE;
		endcase
	endfunction

	fspc_pkg::fspc_arm_e arm;
	logic [2:0]          window;
	logic                busy;
	logic [15:0]         buf_word [WORDS];

	wire       ctrl_hit  = core.io_wr && core.io_addr == `FSPC_CTRL_OFFSET;
	wire [4:0] cmd_bits  = core.io_wdata[4:0];
	// Programming is locked out while the EEPROM is being written
	wire       ctrl_ok   = ctrl_hit && !busy
	                       && !eeprom_write_active_bit_in;
	wire       is_clear  = ctrl_ok && cmd_bits == `FSPC_CMD_CLEAR;
	wire fspc_pkg::fspc_arm_e new_arm = decode_cmd(cmd_bits);
	wire       armed     = arm != fspc_pkg::FSPC_ARM_NONE && !busy;
	wire       store_go  = armed && core.store_prog_mem_instr;
	wire       do_load   = store_go && arm == fspc_pkg::FSPC_ARM_LOAD;
	wire       do_erase  = store_go && arm == fspc_pkg::FSPC_ARM_ERASE;
	wire       do_write  = store_go && arm == fspc_pkg::FSPC_ARM_WRITE;
	// A fuse read during an EEPROM write is refused, not delayed: no
	// answer comes and the core has to issue it again
	wire       do_fuse   = arm == fspc_pkg::FSPC_ARM_FUSE
	                       && core.load_prog_mem_instr
	                       && window < `FSPC_LOAD_WINDOW
	                       && !eeprom_write_active_bit_in;
	// The fourth armed cycle without a store disarms: the page bits'
	// timeout and the enable's timeout are the same event
	wire window_end = armed && window == `FSPC_STORE_WINDOW - 3'h1;

	// ------------------------------------------------------------------
	// Pointer fields
	// ------------------------------------------------------------------
	// Word index drops the byte-select lsb
	wire [WORD_BITS-1:0] word_idx = core.z_pointer[WORD_BITS:1];
	// Page number sits above the word field; other bits ignored
	wire [PAGE_BITS-1:0] page_idx =
		core.z_pointer[WORD_BITS+PAGE_BITS:WORD_BITS+1];
	// Fuse or lock byte chosen by the pointer lsb
	wire [7:0] next_fuse = core.z_pointer[0] ? fuse_bits_in
	                                         : lock_bits_in;

	// ------------------------------------------------------------------
	// Buffer flush and control read-back
	// ------------------------------------------------------------------
	// EEPROM activity flushes on every cycle it lasts, so a load made
	// while it runs is lost as well; the buffer never holds a mix
	wire buf_flush = (busy && arm == fspc_pkg::FSPC_ARM_WRITE
	                  && flash_done_in)
	                 || is_clear
	                 || eeprom_write_active_bit_in;

	// Read-back: reserved bits zero, command bits from armed state
	wire [7:0] ctrl_view = {3'h0, 1'b0,
		arm == fspc_pkg::FSPC_ARM_FUSE,
		arm == fspc_pkg::FSPC_ARM_WRITE,
		arm == fspc_pkg::FSPC_ARM_ERASE,
		arm != fspc_pkg::FSPC_ARM_NONE};
	wire       rd_hit     = core.io_rd && core.io_addr == `FSPC_CTRL_OFFSET;
	// Stall rises with the store and falls with done
	wire       next_stall = do_erase || do_write
	                        || (busy && !flash_done_in);

	// ------------------------------------------------------------------
	// Arming window and operation sequencing
	// ------------------------------------------------------------------
	// While busy the armed command is frozen, so a control write cannot
	// change the page under a running erase or write
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			arm    <= fspc_pkg::FSPC_ARM_NONE;
			window <= 3'h0;
			busy   <= 1'b0;
		end else if (busy) begin
			// Bits stay set until the flash reports completion
			if (flash_done_in) begin
				arm  <= fspc_pkg::FSPC_ARM_NONE;
				busy <= 1'b0;
			end
		end else if (ctrl_ok && new_arm != fspc_pkg::FSPC_ARM_NONE) begin
			arm    <= new_arm;
			window <= 3'h0;
		end else if (do_erase || do_write) begin
			busy <= 1'b1;
		end else if (store_go || do_fuse || window_end) begin
			arm    <= fspc_pkg::FSPC_ARM_NONE;
			window <= 3'h0;
		end else if (armed) begin
			window <= window + 3'h1;
		end
	end

	// ------------------------------------------------------------------
	// Temporary page buffer
	// ------------------------------------------------------------------
	// Erased flash reads all ones, so a word never loaded is written as
	// ffff and leaves that location erased
	genvar gi;
	generate
		for (gi = 0; gi < WORDS; gi++) begin : g_buf
			logic loaded;
			wire  load_hit = do_load && word_idx == WORD_BITS'(gi);
			always_ff @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					loaded       <= 1'b0;
					buf_word[gi] <= 16'hffff;
				end else if (buf_flush) begin
					loaded       <= 1'b0;
					buf_word[gi] <= 16'hffff;
				end else if (load_hit && !loaded) begin
					// Any order; a second load before a clear is dropped,
					// so the first value stands
					loaded       <= 1'b1;
					buf_word[gi] <= core.write_data_pair;
				end
			end
			assign flash_page_data_out[16*gi +: 16] = buf_word[gi];
		end
	endgenerate

	// ------------------------------------------------------------------
	// Outputs to core and flash
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			core.io_rdata       <= 8'h00;
			core.fuse_valid     <= 1'b0;
			core.fuse_data      <= 8'h00;
			core.core_stall     <= 1'b0;
			flash_erase_req_out <= 1'b0;
			flash_write_req_out <= 1'b0;
			flash_page_out      <= '0;
		end else begin
			core.io_rdata   <= rd_hit ? ctrl_view : 8'h00;
			core.fuse_valid <= do_fuse;
			core.fuse_data  <= do_fuse ? next_fuse : 8'h00;
			core.core_stall <= next_stall;
			flash_erase_req_out <= do_erase;
			flash_write_req_out <= do_write;
			if (do_erase || do_write)
				flash_page_out <= page_idx;
		end
	end
endmodule : fspc_device

`default_nettype wire

/* File: design/fspc_host.sv */
// Purpose: Core-side sequencer that drives the self-programming block.
// Assumes: User presents one command at a time while ready_out is high.
// Notes:   Keeps the software-side obligations in hardware.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_regs.svh"

module fspc_host #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              resetn_in,
	// Link to device
	fspc_if.host                   dev,
	// EEPROM status
	input  wire logic              eeprom_write_active_bit_in,
	// User command
	input  wire logic              cmd_valid_in,
	input  wire logic [4:0]        cmd_code_in,
	input  wire logic [ADDR_W-1:0] cmd_addr_in,
	input  wire logic [15:0]       cmd_data_in,
	output logic                   ready_out,
	output logic                   done_out,
	output logic [7:0]             fuse_out
);
	fspc_pkg::fspc_host_e state;
	logic [4:0]           code;
	logic [ADDR_W-1:0]    addr;
	logic [15:0]          data;
	logic [2:0]           wait_cnt;

	wire is_fuse  = code == `FSPC_CMD_READ_FUSE;
	wire is_write = code == `FSPC_CMD_WRITE;
	wire is_long  = is_write || code == `FSPC_CMD_ERASE;
	// Wait for EEPROM idle before touching the control register
	wire go       = cmd_valid_in && !eeprom_write_active_bit_in;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state        <= fspc_pkg::FSPC_H_IDLE;
			code         <= 5'h00;
			addr         <= '0;
			data         <= 16'h0000;
			wait_cnt     <= 3'h0;
			ready_out    <= 1'b0;
			done_out     <= 1'b0;
			fuse_out     <= 8'h00;
			dev.io_wr    <= 1'b0;
			dev.io_rd    <= 1'b0;
			dev.io_addr  <= 6'h00;
			dev.io_wdata <= 8'h00;
			dev.store_prog_mem_instr <= 1'b0;
			dev.load_prog_mem_instr  <= 1'b0;
			dev.z_pointer       <= '0;
			dev.write_data_pair <= 16'h0000;
		end else begin
			dev.io_wr    <= 1'b0;
			dev.io_rd    <= 1'b0;
			dev.store_prog_mem_instr <= 1'b0;
			dev.load_prog_mem_instr  <= 1'b0;
			done_out     <= 1'b0;
			case (state)
				fspc_pkg::FSPC_H_IDLE: begin
					ready_out <= !eeprom_write_active_bit_in;
					if (go && ready_out) begin
						ready_out <= 1'b0;
						code      <= cmd_code_in;
						// Page write: word and byte-select bits [5:0] zeroed
						addr      <= cmd_code_in == `FSPC_CMD_WRITE
						             ? {cmd_addr_in[ADDR_W-1:6], 6'h00}
						             : cmd_addr_in;
						data      <= cmd_data_in;
						state     <= fspc_pkg::FSPC_H_CTRL;
					end
				end
				fspc_pkg::FSPC_H_CTRL: begin
					dev.io_wr    <= 1'b1;
					dev.io_addr  <= `FSPC_CTRL_OFFSET;
					dev.io_wdata <= {3'h0, code};
					dev.z_pointer       <= addr;
					dev.write_data_pair <= data;
					state <= code == `FSPC_CMD_CLEAR ? fspc_pkg::FSPC_H_DONE
					                                 : fspc_pkg::FSPC_H_ISSUE;
				end
				fspc_pkg::FSPC_H_ISSUE: begin
					// Issued the cycle after the control write, inside window
					if (is_fuse)
						dev.load_prog_mem_instr <= 1'b1;
					else
						dev.store_prog_mem_instr <= 1'b1;
					// Read back the armed command beside the instruction
					dev.io_rd <= 1'b1;
					wait_cnt <= 3'h0;
					state    <= fspc_pkg::FSPC_H_WAIT;
				end
				fspc_pkg::FSPC_H_WAIT: begin
					wait_cnt <= wait_cnt + 3'h1;
					if (is_fuse && dev.fuse_valid)
						fuse_out <= dev.fuse_data;
					// Long operations end when the stall drops
					if (!is_long ? wait_cnt == 3'h2
					             : (wait_cnt > 3'h1 && !dev.core_stall))
						state <= fspc_pkg::FSPC_H_DONE;
				end
				fspc_pkg::FSPC_H_DONE: begin
					done_out <= 1'b1;
					state    <= fspc_pkg::FSPC_H_IDLE;
				end
				default: state <= fspc_pkg::FSPC_H_IDLE;
			endcase
		end
	end
endmodule : fspc_host

`default_nettype wire

/* File: dv/fspc_asserts.sv */
// Purpose: Protocol checks on the core link of the self-programming block.
// Assumes: Single clock; host issues its instruction one cycle after the
//          control write, with a read-back of the register beside it.
// Notes:   Sees only link signals, so flash timing is bounded loosely.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_regs.svh"

module fspc_asserts #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              resetn_in,
	// Link signals
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	input  wire logic [5:0]        io_addr,
	input  wire logic [7:0]        io_wdata,
	input  wire logic [7:0]        io_rdata,
	input  wire logic              store_prog_mem_instr,
	input  wire logic              load_prog_mem_instr,
	input  wire logic [ADDR_W-1:0] z_pointer,
	input  wire logic              fuse_valid,
	input  wire logic              core_stall
);
	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	wire       ctrl_wr = io_wr && io_addr == `FSPC_CTRL_OFFSET && !core_stall;
	wire [4:0] cmd     = io_wdata[4:0];

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	property p_erase_stall;
		(ctrl_wr && cmd == `FSPC_CMD_ERASE) ##1 store_prog_mem_instr
			|=> core_stall;
	endproperty
	a_erase_stall: assert property (p_erase_stall)
		else $error("erase store did not stall the core");

	property p_write_stall;
		(ctrl_wr && cmd == `FSPC_CMD_WRITE) ##1 store_prog_mem_instr
			|-> z_pointer[5:0] == 6'h00 ##1 core_stall;
	endproperty
	a_write_stall: assert property (p_write_stall)
		else $error("page write store bad pointer or no stall");

	property p_load_nostall;
		(ctrl_wr && cmd == `FSPC_CMD_LOAD) ##1 store_prog_mem_instr
			|=> !core_stall [*2];
	endproperty
	a_load_nostall: assert property (p_load_nostall)
		else $error("word load stalled the core");

	property p_fuse_answer;
		(ctrl_wr && cmd == `FSPC_CMD_READ_FUSE) ##1 load_prog_mem_instr
			|=> fuse_valid;
	endproperty
	a_fuse_answer: assert property (p_fuse_answer)
		else $error("fuse read gave no answer");

	property p_fuse_cause;
		fuse_valid |-> $past(load_prog_mem_instr);
	endproperty
	a_fuse_cause: assert property (p_fuse_cause)
		else $error("fuse answer without a load");

	property p_reserved;
		io_rdata[7:5] == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved control bits read nonzero");

	// Arming patterns read back as written; clear and anything else read back zero
	property p_readback;
		ctrl_wr ##1 io_rd |=> io_rdata == (($past(cmd, 2) inside
			{5'h09, 5'h05, 5'h03, 5'h01}) ? {3'h0, $past(cmd, 2)} : 8'h00);
	endproperty
	a_readback: assert property (p_readback)
		else $error("control read-back does not match the armed command");

	property p_stall_hold;
		core_stall |-> !store_prog_mem_instr && !io_wr;
	endproperty
	a_stall_hold: assert property (p_stall_hold)
		else $error("core acted while stalled");

	property p_stall_bound;
		$rose(core_stall) |-> ##[1:40] !core_stall;
	endproperty
	a_stall_bound: assert property (p_stall_bound)
		else $error("stall not released after flash done");

	property p_stall_cause;
		$rose(core_stall) |-> $past(store_prog_mem_instr);
	endproperty
	a_stall_cause: assert property (p_stall_cause)
		else $error("stall without a store");

	// Invalid patterns must not arm anything, so a store cannot stall
	property p_invalid;
		(ctrl_wr && !(cmd inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01}))
			##1 store_prog_mem_instr |=> !core_stall;
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("invalid pattern took effect");
endmodule // fspc_asserts

`default_nettype wire

/* File: dv/tb.sv */
// Purpose: Self-checking bench joining host and device ends.
// Assumes: Flash macro modelled here with a random done delay.
// Notes:   Loads use shuffled indices so no word is loaded twice.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_regs.svh"

module tb;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic         clk_in, resetn_in, eeprom_busy, cmd_valid, flash_done;
	logic         ready, done, erase_req, write_req;
	logic [4:0]   cmd_code;
	logic [15:0]  cmd_addr, cmd_data;
	logic [7:0]   fuse_bits, lock_bits, fuse_seen;
	logic [5:0]   page_seen, exp_page;
	logic [511:0] page_data;
	logic [15:0]  exp_buf [32];
	int           mismatches, n_tests, n_req;

	fspc_if #(.ADDR_W(16)) bus ();
	fspc_device i_fspc_device (.clk_in(clk_in), .resetn_in(resetn_in),
		.core(bus), .eeprom_write_active_bit_in(eeprom_busy),
		.fuse_bits_in(fuse_bits), .lock_bits_in(lock_bits),
		.flash_erase_req_out(erase_req), .flash_write_req_out(write_req),
		.flash_page_out(page_seen), .flash_page_data_out(page_data),
		.flash_done_in(flash_done));
	fspc_host i_fspc_host (.clk_in(clk_in), .resetn_in(resetn_in), .dev(bus),
		.eeprom_write_active_bit_in(eeprom_busy), .cmd_valid_in(cmd_valid),
		.cmd_code_in(cmd_code), .cmd_addr_in(cmd_addr),
		.cmd_data_in(cmd_data), .ready_out(ready), .done_out(done),
		.fuse_out(fuse_seen));
	fspc_asserts #(.ADDR_W(16)) i_fspc_asserts (.clk_in(clk_in),
		.resetn_in(resetn_in), .io_wr(bus.io_wr), .io_rd(bus.io_rd),
		.io_addr(bus.io_addr), .io_wdata(bus.io_wdata),
		.io_rdata(bus.io_rdata),
		.store_prog_mem_instr(bus.store_prog_mem_instr),
		.load_prog_mem_instr(bus.load_prog_mem_instr),
		.z_pointer(bus.z_pointer), .fuse_valid(bus.fuse_valid),
		.core_stall(bus.core_stall));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] exp_fuse(input logic z0);
		return z0 ? fuse_bits : lock_bits;
	endfunction

	task automatic check(input logic [15:0] got, exp, input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Sampled at each rising edge, before that edge's updates land
	task automatic wait_hi(ref logic sig);
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge clk_in);
			if (sig === 1'b1) break;
		end
		if (n == 300) begin
			mismatches++;
			end_sim();
		end
	endtask

	task automatic issue(input logic [4:0] code, input logic [15:0] a, d);
		@(posedge clk_in);
		#1 cmd_valid = 1'b1;
		cmd_code = code;
		cmd_addr = a;
		cmd_data = d;
		wait_hi(ready);
		#1 cmd_valid = 1'b0;
		wait_hi(done);
	endtask

	task automatic load(input int idx);
		logic [15:0] d;
		d = 16'($urandom);
		exp_buf[idx] = d;
		issue(`FSPC_CMD_LOAD, {10'($urandom), 5'(idx), 1'($urandom)}, d);
		check(page_data[16*idx +: 16], d, "loaded word");
	endtask

	// ------------------------------------------------------------------
	// Clock and flash macro
	// ------------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	initial begin
		flash_done = 1'b0;
		forever begin
			@(posedge clk_in);
			if (erase_req === 1'b1 || write_req === 1'b1) begin
				n_req++;
				check(16'(page_seen), 16'(exp_page), "flash page");
				if (write_req === 1'b1)
					for (int i = 0; i < 32; i++)
						check(page_data[16*i +: 16], exp_buf[i], "word");
				repeat ($urandom_range(1, 20)) @(posedge clk_in);
				check(16'(bus.core_stall), 16'h0001, "stall");
				#1 flash_done = 1'b1;
				@(posedge clk_in);
				#1 flash_done = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		int idx[$];
		void'($urandom(20));
		{resetn_in, eeprom_busy, cmd_valid, cmd_code} = '0;
		{cmd_addr, cmd_data, mismatches, n_tests, n_req} = '0;
		fuse_bits = 8'($urandom);
		// Kept apart from the fuse byte so a wrong select shows
		lock_bits = ~fuse_bits;
		exp_page = 6'h00;
		repeat (5) @(posedge clk_in);
		#1 resetn_in = 1'b1;
		check(16'(&page_data), 16'h0001, "buffer after reset");
		for (int z = 0; z < 2; z++) begin
			issue(`FSPC_CMD_READ_FUSE, {15'($urandom), 1'(z)}, 16'h0000);
			check(16'(fuse_seen), 16'(exp_fuse(1'(z))), "fuse");
		end
		for (int r = 0; r < 4; r++) begin
			idx = {};
			for (int i = 0; i < 32; i++) idx.push_back(i);
			idx.shuffle();
			exp_page = 6'($urandom);
			for (int i = 0; i < 32; i++) exp_buf[i] = 16'hffff;
			if (r[0]) issue(`FSPC_CMD_ERASE, {4'($urandom), exp_page,
				6'($urandom)}, 16'($urandom));
			for (int i = 0; i < 4 + r * 3; i++) load(idx[i]);
			if (!r[0]) issue(`FSPC_CMD_ERASE, {4'($urandom), exp_page,
				6'($urandom)}, 16'($urandom));
			issue(`FSPC_CMD_WRITE, {4'h0, exp_page, 6'($urandom)}, 16'h0);
			check(16'(&page_data), 16'h0001, "flush after write");
		end
		check(16'(n_req), 16'h0008, "flash requests");
		load(3);
		load(17);
		issue(`FSPC_CMD_CLEAR, 16'($urandom), 16'h0000);
		check(16'(&page_data), 16'h0001, "clear bit");
		load(30);
		#1 eeprom_busy = 1'b1;
		repeat (3) @(posedge clk_in);
		#1 eeprom_busy = 1'b0;
		check(16'(&page_data), 16'h0001, "eeprom discard");
		issue(5'h07, 16'($urandom), 16'($urandom));
		repeat (5) @(posedge clk_in);
		check(16'(n_req), 16'h0008, "invalid pattern");
		end_sim();
	end
endmodule // tb

`default_nettype wire
